// ===== logic/dce_pkg.sv
package dce_pkg;
  localparam logic [7:0] OP_TEST_READY  = 8'h00;
  localparam logic [7:0] OP_READ        = 8'h08;
  localparam logic [7:0] OP_VERIFY      = 8'h09;
  localparam logic [7:0] OP_WRITE       = 8'h0a;
  localparam logic [7:0] OP_SEEK        = 8'h0b;
  localparam logic [7:0] OP_INIT_DRIVE  = 8'h0c;
  localparam logic [7:0] OP_TAPE        = 8'h40;
  localparam logic [7:0] ERR_NONE       = 8'h00;
  localparam logic [7:0] ERR_SEEKING    = 8'h08;
  localparam logic [7:0] ERR_NOT_INIT   = 8'h0a;
  localparam logic [7:0] ERR_BAD_CMD    = 8'h20;
  localparam logic [7:0] ERR_SEEK_FAIL  = 8'h15;
  localparam logic [7:0] ERR_DATA       = 8'h11;
  localparam int         CMD_BYTES      = 6;
  localparam int         PARAM_BYTES    = 8;
  localparam int         ADDR_HI_BIT    = 4;
  localparam int         DRV_HI_BIT     = 6;
  localparam int         DRV_LO_BIT     = 5;
  localparam int         RETRY_BIT      = 7;
  localparam int         ECC_BIT        = 6;
  localparam int         SERVO_BIT      = 7;
  localparam int         SIZE_BIT       = 6;
  localparam logic [8:0] SECTORS_ZERO   = 9'h100;
  localparam logic [4:0] HEADS_HS3_MIN  = 5'h08;
  localparam int         CLK_MHZ        = 100;
  localparam int         SEEK_WAIT_MS   = 2000;
  localparam int         SEEK_WAIT_CYC  = SEEK_WAIT_MS * 1000 * CLK_MHZ;
  localparam logic [15:0] CYL_RST       = 16'h0000;
  localparam logic [3:0]  HEADS_RST     = 4'h0;
  typedef enum logic [1:0] {DCE_CMD_TAPE, DCE_CMD_DISK, DCE_CMD_NODRIVE} dce_target_t;
endpackage

// ===== logic/dce_skid.sv
`timescale 1ns/1ps
// Two-entry buffer: upstream ready depends only on local state, so a stall loses nothing.
module dce_skid (
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic [7:0] in_data,
  input  wire logic       in_valid,
  output logic            in_ready,
  output logic [7:0]      out_data,
  output logic            out_valid,
  input  wire logic       out_ready
);
  logic [7:0] mem_q [2];
  logic       wp_q;
  logic       rp_q;
  logic [1:0] cnt_q;
  logic       room_q;
  wire        push = in_valid && in_ready;
  wire        pop  = out_valid && out_ready;
  wire  [1:0] cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

  // Room is held in a flop so that the host sees ready straight from a register.
  assign in_ready  = room_q;
  assign out_valid = (cnt_q != 2'd0);
  assign out_data  = mem_q[rp_q];

  always_ff @(posedge clk_sys)
  begin
    if (push)
    begin
      mem_q[wp_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'd0;
      room_q <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wp_q <= ~wp_q;
      end
      if (pop)
      begin
        rp_q <= ~rp_q;
      end
      cnt_q  <= cnt_d;
      room_q <= (cnt_d != 2'd2);
    end
  end
endmodule // dce_skid

// ===== logic/dce_exec.sv
`timescale 1ns/1ps
// Summary of operation
// [R1] Verify reads sectors but sends no data
// [R2] Verify checks ID and data, reports errors
// [R3] Verify may overwrite the data buffer
// [R4] Write count sectors from logical address
// [R5] Sector count zero means 256 sectors
// [R6] Byte1 drive bits 6-5; byte5 retry, ECC
// [R7] Seek converts address to cylinder and head
// [R8] Seek status returned immediately
// [R9] Seek verified at next read or write
// [R10] Seek status error only if not issued
// [R11] Both drives may seek concurrently
// [R12] Hold busy on seeking drive except probe
// [R13] Stop waiting two seconds after command
// [R14] Probe on seeking drive returns 08
// [R15] Uninitialized drive access returns 0A
// [R16] Per-drive init; tape gated by drive 0
// [R17] Independent parameter sets per drive
// [R18] Host sends eight parameter bytes, MSB first
// [R19] Sizes one-based; current, precomp zero-based
// [R20] Eight or more heads: line is head bit 3
// [R21] Seven or fewer heads: reduced current from cylinder
// [R22] Param byte2: heads, servo, sector size
// [R23] Size bit selects 512 or 256 byte sectors
// [R24] Logical address is bytes 1..3, MSB first
module dce_exec
  #(parameter int SEEK_WAIT = dce_pkg::SEEK_WAIT_CYC)
(
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  host_data,
  input  wire logic        host_valid,
  output logic             host_ready,
  output logic [7:0]       status_byte,
  output logic             status_valid,
  input  wire logic        status_ready,
  output logic             busy,
  output logic             op_start,
  output logic             op_read,
  output logic             op_write,
  output logic             op_seek,
  output logic             op_to_host,
  output logic             op_retry,
  output logic             op_ecc,
  output logic             op_drive,
  output logic [15:0]      op_cyl,
  output logic [3:0]       op_head,
  output logic [7:0]       op_sector,
  output logic [8:0]       op_count,
  output logic             op_verify_seek,
  output logic             op_sec512,
  output logic             op_servo,
  output logic             rwc_line,
  input  wire logic        op_done,
  input  wire logic        op_err,
  input  wire logic        seek_issue_err,
  input  wire logic [1:0]  seek_complete_pin,
  input  wire logic [15:0] cur_cyl
);
  import dce_pkg::*;

  logic [7:0]  buf_data;
  logic        buf_valid;
  logic        buf_ready;

  dce_skid u_skid (
    .clk_sys   (clk_sys),
    .sys_rst   (sys_rst),
    .in_data   (host_data),
    .in_valid  (host_valid),
    .in_ready  (host_ready),
    .out_data  (buf_data),
    .out_valid (buf_valid),
    .out_ready (buf_ready)
  );

  typedef enum logic [2:0] {S_CMD, S_PARAM, S_DECODE, S_WAIT_SEEK, S_RUN, S_STATUS}
    dce_state_t;
  dce_state_t  st_q;
  logic [7:0]  cmd_q [CMD_BYTES];
  logic [7:0]  par_q [PARAM_BYTES];
  logic [3:0]  idx_q;
  logic [1:0]  init_q;
  logic [1:0]  seeking_q;
  logic [1:0]  unverified_q;
  logic [1:0]  sc_m_q;
  logic [1:0]  sc_q;
  logic [1:0]  sc_prev_q;
  logic [31:0] wait_q;
  logic [15:0] maxcyl_q [2];
  logic [3:0]  heads_q [2];
  logic [15:0] rwc_cyl_q [2];
  logic [1:0]  sec512_q;
  logic [1:0]  servo_q;

  // Byte 1 bit 7 must be zero; bit 4 is unused.
  wire [1:0]  drv_sel = cmd_q[1][DRV_HI_BIT:DRV_LO_BIT]; // [R6]
  wire        drv     = drv_sel[0];
  wire [7:0]  opcode  = cmd_q[0];
  wire [19:0] lba     = {cmd_q[1][ADDR_HI_BIT-1:0], cmd_q[2], cmd_q[3]}; // [R24]
  wire        is_disk = (opcode == OP_READ) || (opcode == OP_VERIFY)
                        || (opcode == OP_WRITE) || (opcode == OP_SEEK);

  function automatic logic drive_ok(input logic [7:0] op, input logic [1:0] d,
                                    input logic [1:0] ini);
    if (op == OP_TAPE)
      return ini[0]; // [R16]
    return (d[1] == 1'b0) && ini[d[0]]; // [R15] [R16]
  endfunction

  // Sectors per track is taken as 32 so the split is a shift; heads are one-based.
  wire [15:0] track   = {1'b0, lba[19:5]};
  wire [4:0]  nheads  = {1'b0, heads_q[drv]};
  wire [15:0] cyl_c   = (nheads == 5'd0) ? 16'h0000 : 16'(track / nheads); // [R7]
  wire [3:0]  head_c  = (nheads == 5'd0) ? 4'h0 : 4'(track % nheads); // [R7]

  assign buf_ready = (st_q == S_CMD) || (st_q == S_PARAM);

  always_ff @(posedge clk_sys)
  begin
    sc_m_q <= seek_complete_pin;
    sc_q   <= sc_m_q;
    sc_prev_q <= sc_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (buf_valid && buf_ready && st_q == S_CMD)
    begin
      cmd_q[idx_q[2:0]] <= buf_data;
    end
    if (buf_valid && buf_ready && st_q == S_PARAM)
    begin
      par_q[idx_q[2:0]] <= buf_data; // [R18]
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      st_q           <= S_CMD;
      idx_q          <= 4'h0;
      init_q         <= 2'b00;
      seeking_q      <= 2'b00;
      unverified_q   <= 2'b00;
      wait_q         <= 32'h0;
      status_byte    <= ERR_NONE;
      status_valid   <= 1'b0;
      busy           <= 1'b0;
      op_start       <= 1'b0;
      op_read        <= 1'b0;
      op_write       <= 1'b0;
      op_seek        <= 1'b0;
      op_to_host     <= 1'b0;
      op_retry       <= 1'b0;
      op_ecc         <= 1'b0;
      op_drive       <= 1'b0;
      op_cyl         <= CYL_RST;
      op_head        <= HEADS_RST;
      op_sector      <= 8'h00;
      op_count       <= 9'h000;
      op_verify_seek <= 1'b0;
      op_sec512      <= 1'b0;
      op_servo       <= 1'b0;
      for (int i = 0; i < 2; i++)
      begin
        maxcyl_q[i]  <= CYL_RST;
        heads_q[i]   <= HEADS_RST;
        rwc_cyl_q[i] <= CYL_RST;
      end
      sec512_q       <= 2'b00;
      servo_q        <= 2'b00;
    end
    else
    begin
      op_start <= 1'b0;
      // Seek completion clears the outstanding flag on either drive at any time.
      // The line idles high and only falls once the drive moves, so its level would
      // clear a fresh seek; only its return high counts as completion.
      for (int d = 0; d < 2; d++)
      begin
        if (sc_q[d] && !sc_prev_q[d])
        begin
          seeking_q[d] <= 1'b0; // [R11]
        end
      end
      unique case (st_q)
        S_CMD:
        begin
          if (buf_valid)
          begin
            if (idx_q == 4'(CMD_BYTES - 1))
            begin
              idx_q <= 4'h0;
              st_q  <= S_DECODE;
            end
            else
            begin
              idx_q <= idx_q + 4'h1;
            end
          end
        end
        S_PARAM:
        begin
          if (buf_valid)
          begin
            if (idx_q == 4'(PARAM_BYTES - 1))
            begin
              idx_q <= 4'h0;
              // Two-byte fields arrive MSB first; sizes stored one-based as sent.
              maxcyl_q[drv]  <= {par_q[0], par_q[1]}; // [R17] [R19]
              heads_q[drv]   <= par_q[2][3:0]; // [R22]
              servo_q[drv]   <= par_q[2][SERVO_BIT]; // [R22]
              sec512_q[drv]  <= par_q[2][SIZE_BIT]; // [R22] [R23]
              rwc_cyl_q[drv] <= {par_q[3], par_q[4]}; // [R19] [R21]
              init_q[drv]    <= 1'b1; // [R16]
              status_byte    <= ERR_NONE;
              status_valid   <= 1'b1;
              st_q           <= S_STATUS;
            end
            else
            begin
              idx_q <= idx_q + 4'h1;
            end
          end
        end
        S_DECODE:
        begin
          busy <= 1'b1;
          if (opcode == OP_INIT_DRIVE)
          begin
            st_q <= S_PARAM; // [R18]
          end
          else if (opcode == OP_TEST_READY)
          begin
            // The probe never waits on a seek.
            status_byte  <= seeking_q[drv] ? ERR_SEEKING : ERR_NONE; // [R12] [R14]
            status_valid <= 1'b1;
            st_q         <= S_STATUS;
          end
          else if ((is_disk || opcode == OP_TAPE) && !drive_ok(opcode, drv_sel, init_q))
          begin
            status_byte  <= ERR_NOT_INIT; // [R15]
            status_valid <= 1'b1;
            st_q         <= S_STATUS;
          end
          else if (!is_disk)
          begin
            status_byte  <= ERR_BAD_CMD;
            status_valid <= 1'b1;
            st_q         <= S_STATUS;
          end
          else
          begin
            wait_q <= 32'h0;
            st_q   <= S_WAIT_SEEK; // [R12]
          end
        end
        S_WAIT_SEEK:
        begin
          wait_q <= wait_q + 32'h1;
          // Give up after the wait limit so a stuck drive cannot hang the host.
          if (!seeking_q[drv] || wait_q >= 32'(SEEK_WAIT - 1)) // [R12] [R13]
          begin
            seeking_q[drv] <= 1'b0;
            op_start       <= (opcode != OP_SEEK);
            op_seek        <= (opcode == OP_SEEK);
            op_read        <= (opcode == OP_READ) || (opcode == OP_VERIFY); // [R1]
            op_write       <= (opcode == OP_WRITE); // [R4]
            op_to_host     <= (opcode == OP_READ); // [R1] [R3]
            op_retry       <= cmd_q[5][RETRY_BIT]; // [R6]
            op_ecc         <= cmd_q[5][ECC_BIT]; // [R6]
            op_drive       <= drv;
            op_cyl         <= cyl_c; // [R7]
            op_head        <= head_c; // [R7]
            op_sector      <= {3'b000, lba[4:0]};
            op_count       <= (cmd_q[4] == 8'h00) ? SECTORS_ZERO : {1'b0, cmd_q[4]}; // [R5]
            op_verify_seek <= unverified_q[drv]; // [R9]
            op_sec512      <= sec512_q[drv]; // [R23]
            op_servo       <= servo_q[drv];
            if (opcode == OP_SEEK)
            begin
              // Status goes back at once; the drive keeps moving.
              status_byte  <= seek_issue_err ? ERR_SEEK_FAIL : ERR_NONE; // [R8] [R10]
              status_valid <= 1'b1;
              if (!seek_issue_err)
              begin
                seeking_q[drv]    <= 1'b1; // [R11]
                unverified_q[drv] <= 1'b1; // [R9]
              end
              st_q <= S_STATUS;
            end
            else
            begin
              unverified_q[drv] <= 1'b0; // [R9]
              st_q <= S_RUN;
            end
          end
        end
        S_RUN:
        begin
          if (op_done)
          begin
            op_read      <= 1'b0;
            op_write     <= 1'b0;
            // ID and data field faults both surface here.
            status_byte  <= op_err ? ERR_DATA : ERR_NONE; // [R2]
            status_valid <= 1'b1;
            st_q         <= S_STATUS;
          end
        end
        S_STATUS:
        begin
          op_seek <= 1'b0;
          if (status_ready)
          begin
            status_valid <= 1'b0;
            busy         <= 1'b0;
            st_q         <= S_CMD;
          end
        end
        default:
        begin
          st_q <= S_CMD;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      rwc_line <= 1'b0;
    end
    else if (heads_q[op_drive] >= HEADS_HS3_MIN[3:0])
    begin
      rwc_line <= op_head[3]; // [R20]
    end
    else
    begin
      rwc_line <= (cur_cyl >= rwc_cyl_q[op_drive]); // [R21]
    end
  end
endmodule // dce_exec

// ===== tb/dce_exec_asserts.sv
`timescale 1ns/1ps
module dce_exec_asserts
  #(parameter int SEEK_WAIT = 50)
(
  input wire logic       clk_sys,
  input wire logic       sys_rst,
  input wire logic [7:0] status_byte,
  input wire logic       status_valid,
  input wire logic       status_ready,
  input wire logic       busy,
  input wire logic       op_start,
  input wire logic       op_read,
  input wire logic       op_write,
  input wire logic       op_seek,
  input wire logic       op_to_host,
  input wire logic [8:0] op_count
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  logic [31:0] busy_cnt_q;
  // Counts how long busy lasts without status, since the seek wait must give up.
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst || !busy || status_valid)
      busy_cnt_q <= '0;
    else
      busy_cnt_q <= busy_cnt_q + 32'h1;
  end
  property p_status_busy; status_valid |-> busy; endproperty
  a_status_busy: assert property (p_status_busy) else $error("status without busy");
  property p_status_hold;
    status_valid && !status_ready |=> status_valid && $stable(status_byte);
  endproperty
  a_status_hold: assert property (p_status_hold) else $error("status dropped early");
  property p_busy_drop; status_valid && status_ready |=> !busy && !status_valid; endproperty
  a_busy_drop: assert property (p_busy_drop) else $error("busy after status");
  property p_host_read; op_start && op_to_host |-> op_read; endproperty
  a_host_read: assert property (p_host_read) else $error("data to host not read");
  property p_write_dir; op_start && op_write |-> !op_to_host && !op_read; endproperty
  a_write_dir: assert property (p_write_dir) else $error("write direction wrong");
  property p_count; op_start |-> op_count != 9'h000 && op_count <= 9'h100; endproperty
  a_count: assert property (p_count) else $error("sector count out of range");
  property p_start_pulse; op_start |=> !op_start; endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not a pulse");
  property p_seek_status; $rose(op_seek) |-> status_valid; endproperty
  a_seek_status: assert property (p_seek_status) else $error("seek without status");
  property p_wait_bound; busy_cnt_q <= SEEK_WAIT + 40; endproperty
  a_wait_bound: assert property (p_wait_bound) else $error("busy too long");
endmodule // dce_exec_asserts

// ===== tb/dce_drive_model.sv
`timescale 1ns/1ps
module dce_drive_model
  #(parameter int DONE_LAT = 5)
(
  input  wire logic       clk_sys,
  input  wire logic       sys_rst,
  input  wire logic       op_start,
  input  wire logic       op_seek,
  input  wire logic       op_drive,
  input  wire logic       err_req,
  input  wire logic [7:0] seek_lat,
  output logic            op_done,
  output logic            op_err,
  output logic [1:0]      seek_complete_pin
);
  logic [7:0] op_cnt_q;
  logic [7:0] seek_cnt_q [2];
  logic       seek_prev_q;
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      op_cnt_q <= 8'h00;
    else if (op_start)
      op_cnt_q <= 8'(DONE_LAT);
    else if (op_cnt_q != 8'h00)
      op_cnt_q <= op_cnt_q - 8'h01;
    op_done <= !sys_rst && op_cnt_q == 8'h01;
    op_err <= !sys_rst && op_cnt_q == 8'h01 && err_req;
  end
  // A latency of ff never completes, to exercise the give-up path of the wait.
  always_ff @(posedge clk_sys)
  begin
    seek_prev_q <= !sys_rst && op_seek;
    for (int d = 0; d < 2; d++)
    begin
      if (sys_rst)
      begin
        seek_cnt_q[d] <= 8'h00;
        seek_complete_pin[d] <= 1'b1;
      end
      else if (op_seek && !seek_prev_q && op_drive == d[0])
      begin
        seek_cnt_q[d] <= seek_lat;
        seek_complete_pin[d] <= 1'b0;
      end
      else if (seek_cnt_q[d] != 8'h00 && seek_cnt_q[d] != 8'hff)
      begin
        seek_cnt_q[d] <= seek_cnt_q[d] - 8'h01;
        seek_complete_pin[d] <= seek_cnt_q[d] == 8'h01;
      end
    end
  end
endmodule // dce_drive_model

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dce_pkg::*;
  localparam int SEEK_WAIT = 50;
  typedef struct packed {
    logic [47:0] cmd;
    logic [7:0]  st;
    logic [8:0]  cnt;
    logic        host;
  } dce_row_t;
  logic        clk_sys = 1'b0, sys_rst = 1'b1, host_valid = 1'b0, status_ready = 1'b0;
  logic        seek_issue_err = 1'b0, err_req = 1'b0;
  logic [7:0]  host_data = 8'h00, seek_lat = 8'h28, status_byte, got;
  logic [15:0] cur_cyl = 16'h0000, op_cyl, seen_cyl;
  logic [3:0]  seen_head;
  logic        seen_vs, seen_ecc, seen_sec;
  logic        host_ready, status_valid, busy, op_start, op_read, op_write, op_seek;
  logic        op_to_host, op_retry, op_ecc, op_drive, op_verify_seek, op_sec512, op_servo;
  logic        rwc_line, op_done, op_err, seen_host, got_ok;
  logic [3:0]  op_head;
  logic [7:0]  op_sector;
  logic [8:0]  op_count, seen_cnt;
  logic [1:0]  seek_complete_pin;
  int          failures = 0, checks_done = 0;
  logic [7:0]  prm [8] = '{8'h01, 8'h32, 8'h46, 8'h00, 8'hc8, 8'h01, 8'h00, 8'h00};
  dce_row_t    rows [11] = '{
    '{48'h08_00_00_10_01_c0, ERR_NOT_INIT, 9'h000, 1'b0},
    '{48'h0a_20_00_00_01_c0, ERR_NOT_INIT, 9'h000, 1'b0},
    '{48'h40_00_00_00_00_00, ERR_NOT_INIT, 9'h000, 1'b0},
    '{48'h0c_00_00_00_00_00, ERR_NONE, 9'h000, 1'b0},
    '{48'h08_00_00_10_00_c0, ERR_NONE, 9'h100, 1'b1},
    '{48'h09_00_00_20_03_c0, ERR_NONE, 9'h003, 1'b0},
    '{48'h0a_00_00_40_ff_80, ERR_NONE, 9'h0ff, 1'b0},
    '{48'h0a_20_00_00_01_80, ERR_NOT_INIT, 9'h000, 1'b0},
    '{48'h0b_00_01_00_00_00, ERR_NONE, 9'h000, 1'b0},
    '{48'h00_00_00_00_00_00, ERR_SEEKING, 9'h000, 1'b0},
    '{48'h08_00_01_00_01_c0, ERR_NONE, 9'h001, 1'b1}};
  dce_exec #(.SEEK_WAIT(SEEK_WAIT)) dut (.*);
  dce_drive_model model (.*);
  initial forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (op_start === 1'b1)
    begin
      seen_cnt <= op_count;
      seen_host <= op_to_host;
      seen_cyl <= op_cyl;
      seen_head <= op_head;
      seen_vs <= op_verify_seek;
      seen_ecc <= op_ecc;
      seen_sec <= op_sec512;
    end
  task automatic summarize;
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Ready is sampled at the falling edge, so the byte is held across the taking edge.
  task automatic send(input logic [7:0] b);
    host_data <= b;
    host_valid <= 1'b1;
    do @(negedge clk_sys); while (host_ready !== 1'b1);
    @(posedge clk_sys);
  endtask
  task automatic run(input logic [47:0] c);
    int n;
    for (int i = 5; i >= 0; i--)
      send(c[i*8+:8]);
    if (c[47:40] == OP_INIT_DRIVE)
      for (int i = 0; i < 8; i++)
        send(prm[i]);
    host_valid <= 1'b0;
    status_ready <= 1'b1;
    n = 0;
    do
    begin
      @(negedge clk_sys);
      n++;
    end
    while (n < 300 && status_valid !== 1'b1);
    got = status_byte;
    got_ok = status_valid;
    check({15'h0000, got_ok}, 16'h0001);
    @(posedge clk_sys);
    status_ready <= 1'b0;
  endtask
  initial
  begin
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int r = 0; r < 11; r++)
    begin
      run(rows[r].cmd);
      check({8'h00, got}, {8'h00, rows[r].st});
      if (rows[r].cnt != 9'h000)
      begin
        check({7'h00, seen_cnt}, {7'h00, rows[r].cnt});
        check({15'h0000, seen_host}, {15'h0000, rows[r].host});
      end
    end
    // Last row read logical sector 256 on drive 0: track 8, six heads, seek pending.
    check(seen_cyl, 16'h0001);
    check({12'h000, seen_head}, 16'h0002);
    check({15'h0000, seen_vs}, 16'h0001);
    check({15'h0000, seen_ecc}, 16'h0001);
    check({15'h0000, seen_sec}, 16'h0001);
    cur_cyl <= 16'h00c7;
    repeat (4) @(negedge clk_sys);
    check({15'h0000, rwc_line}, 16'h0000);
    cur_cyl <= 16'h00c8;
    repeat (4) @(negedge clk_sys);
    check({15'h0000, rwc_line}, 16'h0001);
    @(posedge clk_sys);
    err_req <= 1'b1;
    run(48'h09_00_00_20_01_c0);
    check({8'h00, got}, {8'h00, ERR_DATA});
    err_req <= 1'b0;
    seek_issue_err <= 1'b1;
    run(48'h0b_00_02_00_00_00);
    check({8'h00, got}, {8'h00, ERR_SEEK_FAIL});
    seek_issue_err <= 1'b0;
    seek_lat <= 8'hff;
    run(48'h0b_00_03_00_00_00);
    run(48'h08_00_03_00_01_c0);
    check({15'h0000, got_ok}, 16'h0001);
    check({8'h00, got}, {8'h00, ERR_NONE});
    sys_rst <= 1'b1;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    run(48'h08_00_00_10_01_c0);
    check({8'h00, got}, {8'h00, ERR_NOT_INIT});
    summarize();
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    summarize();
  end
endmodule // tb_top
bind dce_exec dce_exec_asserts #(.SEEK_WAIT(SEEK_WAIT)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .status_byte(status_byte),
  .status_valid(status_valid), .status_ready(status_ready), .busy(busy),
  .op_start(op_start), .op_read(op_read), .op_write(op_write), .op_seek(op_seek),
  .op_to_host(op_to_host), .op_count(op_count));
